/* File: hw/cef_pkg.sv */
// Package for the charger event flag bank: addresses, bit layout, edge kinds and carriers
package cef_pkg;

   // Register addresses on the device register port
   localparam logic [7:0] ADDR_CHG_FLAGS_TWO = 8'h24;
   localparam logic [7:0] ADDR_CHG_FLAGS_THREE = 8'h25;
   localparam logic [7:0] ADDR_FAULT_FLAGS_ZERO = 8'h26;

   // Flag reset value and register width
   localparam int REG_W = 8;
   localparam int BANK_W = 24;
   localparam logic [7:0] FLAG_RESET = 8'h00;

   // Bit positions inside the charger flags two register
   localparam int B2_DATA_LINE_DONE = 6;
   localparam int B2_CONVERSION_DONE = 5;
   localparam int B2_MIN_SYS_REG = 4;
   localparam int B2_FAST_TMR = 3;
   localparam int B2_TRICKLE_TMR = 2;
   localparam int B2_PRECHG_TMR = 1;
   localparam int B2_TOP_OFF_TMR = 0;

   // Bit positions inside the charger flags three register
   localparam int B3_BAT_LOW_SRC = 4;
   localparam int B3_COLD = 3;
   localparam int B3_COOL = 2;
   localparam int B3_WARM = 1;
   localparam int B3_HOT = 0;

   // Bit positions inside the fault flags zero register
   localparam int BF_BAT_CUR_REG = 7;
   localparam int BF_BUS_OVP = 6;
   localparam int BF_BAT_OVP = 5;
   localparam int BF_IN_OCP = 4;
   localparam int BF_DIS_OCP = 3;
   localparam int BF_CONV_OCP = 2;
   localparam int BF_IN2_OVP = 1;
   localparam int BF_IN1_OVP = 0;

   // Bits that flag on any change rather than on a rising edge ({fault, three, two})
   localparam logic [23:0] ANY_EDGE_MASK = 24'h800F10;
   // Reserved bits, never set and always read as zero
   localparam logic [23:0] RSVD_MASK = 24'h00E080;

   // Condition levels from the charger core, one per flag
   typedef struct packed {
      logic data_line_detect_done;
      logic conversion_done;
      logic min_system_voltage_reg;
      logic fast_charge_expired;
      logic trickle_expired;
      logic precharge_expired;
      logic top_off_expired;
      logic battery_low_for_source;
      logic thermistor_cold;
      logic thermistor_cool;
      logic thermistor_warm;
      logic thermistor_hot;
      logic battery_current_reg;
      logic input_bus_ovp;
      logic battery_ovp;
      logic input_ocp;
      logic discharge_ocp;
      logic converter_ocp;
      logic second_input_ovp;
      logic first_input_ovp;
   } cef_cond_s;

   // The three flag registers as one bank
   typedef struct packed {
      logic [7:0] fault_event_flags_zero;
      logic [7:0] charger_event_flags_three;
      logic [7:0] charger_event_flags_two;
   } cef_bank_s;

   // Whole state of the flag bank
   typedef struct packed {
      logic [23:0] prev_lvl;
      cef_bank_s flags;
      logic primed;
      logic [7:0] rd_data;
      logic rd_valid;
      logic int_pulse;
   } cef_state_s;

endpackage : cef_pkg

/* File: hw/cef_flag_bank.sv */
// Charger event flag bank: three read-to-clear event flag registers with interrupt pulse
`timescale 1ns/100ps
`default_nettype none

module cef_flag_bank
   import cef_pkg::*;
(
   input wire logic mclk_i,
   input wire logic arst_n_i,
   input wire cef_cond_s cond_i,
   input wire cef_bank_s mask_i,
   input wire logic rd_en_i,
   input wire logic [7:0] rd_addr_i,
   output logic [7:0] rd_data_o,
   output logic rd_valid_o,
   output logic int_pulse_o
);

   cef_state_s st_ff;
   cef_state_s nxt_st;
   logic [23:0] lvl;
   logic [23:0] evt;
   logic [23:0] rd_clr;
   logic [23:0] mask_vec;

   ////////////////////////////////////////////////////////////////////////////
   // Condition levels placed at their flag positions
   always_comb begin
      lvl = '0;
      lvl[B2_DATA_LINE_DONE] = cond_i.data_line_detect_done;
      lvl[B2_CONVERSION_DONE] = cond_i.conversion_done;
      lvl[B2_MIN_SYS_REG] = cond_i.min_system_voltage_reg;
      lvl[B2_FAST_TMR] = cond_i.fast_charge_expired;
      lvl[B2_TRICKLE_TMR] = cond_i.trickle_expired;
      lvl[B2_PRECHG_TMR] = cond_i.precharge_expired;
      lvl[B2_TOP_OFF_TMR] = cond_i.top_off_expired;
      lvl[REG_W + B3_BAT_LOW_SRC] = cond_i.battery_low_for_source;
      lvl[REG_W + B3_COLD] = cond_i.thermistor_cold;
      lvl[REG_W + B3_COOL] = cond_i.thermistor_cool;
      lvl[REG_W + B3_WARM] = cond_i.thermistor_warm;
      lvl[REG_W + B3_HOT] = cond_i.thermistor_hot;
      lvl[2*REG_W + BF_BAT_CUR_REG] = cond_i.battery_current_reg;
      lvl[2*REG_W + BF_BUS_OVP] = cond_i.input_bus_ovp;
      lvl[2*REG_W + BF_BAT_OVP] = cond_i.battery_ovp;
      lvl[2*REG_W + BF_IN_OCP] = cond_i.input_ocp;
      lvl[2*REG_W + BF_DIS_OCP] = cond_i.discharge_ocp;
      lvl[2*REG_W + BF_CONV_OCP] = cond_i.converter_ocp;
      lvl[2*REG_W + BF_IN2_OVP] = cond_i.second_input_ovp;
      lvl[2*REG_W + BF_IN1_OVP] = cond_i.first_input_ovp;
   end

   assign mask_vec = mask_i;

   ////////////////////////////////////////////////////////////////////////////
   // Per-bit event detection: rising edge or any change, reserved bits never fire
   for (genvar gi = 0; gi < BANK_W; gi++) begin : g_evt
      if (RSVD_MASK[gi]) begin : g_rsvd
         assign evt[gi] = 1'b0;
      end else if (ANY_EDGE_MASK[gi]) begin : g_any
         assign evt[gi] = st_ff.primed & (lvl[gi] ^ st_ff.prev_lvl[gi]);
      end else begin : g_rise
         assign evt[gi] = st_ff.primed & lvl[gi] & ~st_ff.prev_lvl[gi];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read decode picks which register a read clears
   always_comb begin
      rd_clr = '0;
      if (rd_en_i && rd_addr_i == ADDR_CHG_FLAGS_TWO) begin
         rd_clr[7:0] = 8'hFF;
      end else if (rd_en_i && rd_addr_i == ADDR_CHG_FLAGS_THREE) begin
         rd_clr[15:8] = 8'hFF;
      end else if (rd_en_i && rd_addr_i == ADDR_FAULT_FLAGS_ZERO) begin
         rd_clr[23:16] = 8'hFF;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state: flags, read data and interrupt pulse
   always_comb begin
      nxt_st = st_ff;
      nxt_st.prev_lvl = lvl;
      nxt_st.primed = 1'b1;
      // A new event wins over the clear of the read in the same cycle
      nxt_st.flags = cef_bank_s'((st_ff.flags & ~rd_clr) | evt);
      nxt_st.rd_valid = rd_en_i;
      // Read returns the held flags; unmapped addresses read zero
      if (rd_en_i && rd_addr_i == ADDR_CHG_FLAGS_TWO) begin
         nxt_st.rd_data = st_ff.flags.charger_event_flags_two & ~RSVD_MASK[7:0];
      end else if (rd_en_i && rd_addr_i == ADDR_CHG_FLAGS_THREE) begin
         nxt_st.rd_data = st_ff.flags.charger_event_flags_three & ~RSVD_MASK[15:8];
      end else if (rd_en_i && rd_addr_i == ADDR_FAULT_FLAGS_ZERO) begin
         nxt_st.rd_data = st_ff.flags.fault_event_flags_zero;
      end else begin
         nxt_st.rd_data = FLAG_RESET;
      end
      nxt_st.int_pulse = |(evt & ~mask_vec);
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register, all zero at reset
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign rd_data_o = st_ff.rd_data;
   assign rd_valid_o = st_ff.rd_valid;
   assign int_pulse_o = st_ff.int_pulse;

   ////////////////////////////////////////////////////////////////////////////
   // Checks on flag behaviour
   property p_dl_done_sets;
      @(posedge mclk_i) disable iff (!arst_n_i)
      st_ff.primed && cond_i.data_line_detect_done && !st_ff.prev_lvl[B2_DATA_LINE_DONE]
      |=> st_ff.flags.charger_event_flags_two[B2_DATA_LINE_DONE];
   endproperty
   a_dl_done_sets: assert property (p_dl_done_sets) else $error("data line done flag not set");

   property p_min_sys_change;
      @(posedge mclk_i) disable iff (!arst_n_i)
      st_ff.primed && (cond_i.min_system_voltage_reg != st_ff.prev_lvl[B2_MIN_SYS_REG])
      |=> st_ff.flags.charger_event_flags_two[B2_MIN_SYS_REG];
   endproperty
   a_min_sys_change: assert property (p_min_sys_change) else $error("min system flag missed change");

   property p_fast_tmr_rise;
      @(posedge mclk_i) disable iff (!arst_n_i)
      st_ff.primed && $rose(cond_i.fast_charge_expired) |=> st_ff.flags.charger_event_flags_two[B2_FAST_TMR];
   endproperty
   a_fast_tmr_rise: assert property (p_fast_tmr_rise) else $error("fast timer flag missed");

   property p_fast_tmr_fall_quiet;
      @(posedge mclk_i) disable iff (!arst_n_i)
      !st_ff.flags.charger_event_flags_two[B2_FAST_TMR] && !lvl[B2_FAST_TMR]
      |=> !st_ff.flags.charger_event_flags_two[B2_FAST_TMR];
   endproperty
   a_fast_tmr_fall_quiet: assert property (p_fast_tmr_fall_quiet) else $error("fast timer flag set without edge");

   property p_cold_cross;
      @(posedge mclk_i) disable iff (!arst_n_i)
      st_ff.primed && (cond_i.thermistor_cold != st_ff.prev_lvl[REG_W + B3_COLD])
      |=> st_ff.flags.charger_event_flags_three[B3_COLD];
   endproperty
   a_cold_cross: assert property (p_cold_cross) else $error("cold flag missed crossing");

   property p_bat_cur_change;
      @(posedge mclk_i) disable iff (!arst_n_i)
      st_ff.primed && $changed(cond_i.battery_current_reg) && $past(st_ff.primed)
      |=> st_ff.flags.fault_event_flags_zero[BF_BAT_CUR_REG];
   endproperty
   a_bat_cur_change: assert property (p_bat_cur_change) else $error("battery current flag missed");

   property p_bus_ovp_rise;
      @(posedge mclk_i) disable iff (!arst_n_i)
      st_ff.primed && cond_i.input_bus_ovp && !st_ff.prev_lvl[2*REG_W + BF_BUS_OVP]
      ##1 !(rd_en_i && rd_addr_i == ADDR_FAULT_FLAGS_ZERO)
      |-> st_ff.flags.fault_event_flags_zero[BF_BUS_OVP] [*2];
   endproperty
   a_bus_ovp_rise: assert property (p_bus_ovp_rise) else $error("bus over-voltage flag not held");

   // Reserved bits stay clear in the bank and in what a read of either charger register returns
   property p_rsvd_zero;
      @(posedge mclk_i) disable iff (!arst_n_i)
      rd_en_i && rd_addr_i == ADDR_CHG_FLAGS_THREE
      |=> rd_valid_o && (rd_data_o & RSVD_MASK[15:8]) == 8'h00 && (st_ff.flags & RSVD_MASK) == 24'h000000;
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit seen set");

   property p_rsvd_two;
      @(posedge mclk_i) disable iff (!arst_n_i)
      rd_en_i && rd_addr_i == ADDR_CHG_FLAGS_TWO |=> rd_valid_o && (rd_data_o & RSVD_MASK[7:0]) == 8'h00;
   endproperty
   a_rsvd_two: assert property (p_rsvd_two) else $error("reserved bit read as one");

   property p_read_returns;
      @(posedge mclk_i) disable iff (!arst_n_i)
      rd_en_i && rd_addr_i == ADDR_CHG_FLAGS_THREE |=> rd_valid_o && rd_data_o == $past(st_ff.flags[15:8]);
   endproperty
   a_read_returns: assert property (p_read_returns) else $error("read data mismatch");

   property p_read_clears;
      @(posedge mclk_i) disable iff (!arst_n_i)
      rd_en_i && rd_addr_i == ADDR_CHG_FLAGS_TWO && evt[7:0] == 8'h00
      |=> st_ff.flags.charger_event_flags_two == 8'h00;
   endproperty
   a_read_clears: assert property (p_read_clears) else $error("flag not cleared by read");

   property p_int_masked;
      @(posedge mclk_i) disable iff (!arst_n_i)
      (evt & ~mask_vec) == 24'h000000 |=> !int_pulse_o;
   endproperty
   a_int_masked: assert property (p_int_masked) else $error("pulse from masked event");

   property p_int_unmasked;
      @(posedge mclk_i) disable iff (!arst_n_i)
      (evt & ~mask_vec) != 24'h000000 |=> int_pulse_o;
   endproperty
   a_int_unmasked: assert property (p_int_unmasked) else $error("unmasked event gave no pulse");

   ////////////////////////////////////////////////////////////////////////////
   // Set checks for the remaining flags except conversion done, one per event source
   property p_trickle_rise;
      @(posedge mclk_i) disable iff (!arst_n_i)
      st_ff.primed && $rose(cond_i.trickle_expired)
      |=> st_ff.flags.charger_event_flags_two[B2_TRICKLE_TMR];
   endproperty
   a_trickle_rise: assert property (p_trickle_rise) else $error("trickle timer flag missed");

   property p_precharge_rise;
      @(posedge mclk_i) disable iff (!arst_n_i)
      st_ff.primed && $rose(cond_i.precharge_expired)
      |=> st_ff.flags.charger_event_flags_two[B2_PRECHG_TMR];
   endproperty
   a_precharge_rise: assert property (p_precharge_rise) else $error("pre-charge timer flag missed");

   property p_top_off_rise;
      @(posedge mclk_i) disable iff (!arst_n_i)
      st_ff.primed && $rose(cond_i.top_off_expired)
      |=> st_ff.flags.charger_event_flags_two[B2_TOP_OFF_TMR];
   endproperty
   a_top_off_rise: assert property (p_top_off_rise) else $error("top-off timer flag missed");

   property p_bat_low_rise;
      @(posedge mclk_i) disable iff (!arst_n_i)
      st_ff.primed && $rose(cond_i.battery_low_for_source)
      |=> st_ff.flags.charger_event_flags_three[B3_BAT_LOW_SRC];
   endproperty
   a_bat_low_rise: assert property (p_bat_low_rise) else $error("battery low flag missed");

   property p_cool_cross;
      @(posedge mclk_i) disable iff (!arst_n_i)
      st_ff.primed && $changed(cond_i.thermistor_cool)
      |=> st_ff.flags.charger_event_flags_three[B3_COOL];
   endproperty
   a_cool_cross: assert property (p_cool_cross) else $error("cool flag missed crossing");

   property p_warm_cross;
      @(posedge mclk_i) disable iff (!arst_n_i)
      st_ff.primed && $changed(cond_i.thermistor_warm)
      |=> st_ff.flags.charger_event_flags_three[B3_WARM];
   endproperty
   a_warm_cross: assert property (p_warm_cross) else $error("warm flag missed crossing");

   property p_hot_cross;
      @(posedge mclk_i) disable iff (!arst_n_i)
      st_ff.primed && $changed(cond_i.thermistor_hot)
      |=> st_ff.flags.charger_event_flags_three[B3_HOT];
   endproperty
   a_hot_cross: assert property (p_hot_cross) else $error("hot flag missed crossing");

   property p_in2_ovp_rise;
      @(posedge mclk_i) disable iff (!arst_n_i)
      st_ff.primed && $rose(cond_i.second_input_ovp)
      |=> st_ff.flags.fault_event_flags_zero[BF_IN2_OVP];
   endproperty
   a_in2_ovp_rise: assert property (p_in2_ovp_rise) else $error("second input over-voltage flag missed");

   property p_in1_ovp_rise;
      @(posedge mclk_i) disable iff (!arst_n_i)
      st_ff.primed && $rose(cond_i.first_input_ovp)
      |=> st_ff.flags.fault_event_flags_zero[BF_IN1_OVP];
   endproperty
   a_in1_ovp_rise: assert property (p_in1_ovp_rise) else $error("first input over-voltage flag missed");

   property p_bat_ovp_rise;
      @(posedge mclk_i) disable iff (!arst_n_i)
      st_ff.primed && $rose(cond_i.battery_ovp)
      |=> st_ff.flags.fault_event_flags_zero[BF_BAT_OVP];
   endproperty
   a_bat_ovp_rise: assert property (p_bat_ovp_rise) else $error("battery over-voltage flag missed");

   property p_in_ocp_rise;
      @(posedge mclk_i) disable iff (!arst_n_i)
      st_ff.primed && $rose(cond_i.input_ocp)
      |=> st_ff.flags.fault_event_flags_zero[BF_IN_OCP];
   endproperty
   a_in_ocp_rise: assert property (p_in_ocp_rise) else $error("input over-current flag missed");

   property p_dis_ocp_rise;
      @(posedge mclk_i) disable iff (!arst_n_i)
      st_ff.primed && $rose(cond_i.discharge_ocp)
      |=> st_ff.flags.fault_event_flags_zero[BF_DIS_OCP];
   endproperty
   a_dis_ocp_rise: assert property (p_dis_ocp_rise) else $error("discharge over-current flag missed");

   property p_conv_ocp_rise;
      @(posedge mclk_i) disable iff (!arst_n_i)
      st_ff.primed && $rose(cond_i.converter_ocp)
      |=> st_ff.flags.fault_event_flags_zero[BF_CONV_OCP];
   endproperty
   a_conv_ocp_rise: assert property (p_conv_ocp_rise) else $error("converter over-current flag missed");

   // Nothing flags or pulses on the edge that only captures levels after reset
   property p_reset_quiet;
      @(posedge mclk_i) disable iff (!arst_n_i)
      !st_ff.primed |=> st_ff.flags == 24'h000000 && !int_pulse_o;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("flag or pulse right after reset");

   // An event in the cycle of its register's read survives the clear
   property p_set_wins;
      @(posedge mclk_i) disable iff (!arst_n_i)
      (rd_clr & evt) != 24'h000000
      |=> (st_ff.flags & $past(rd_clr) & $past(evt)) == ($past(rd_clr) & $past(evt));
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("same-cycle event lost to read clear");

   // Held flags of the temperature register survive every cycle without a read of it
   property p_three_holds;
      @(posedge mclk_i) disable iff (!arst_n_i)
      !(rd_en_i && rd_addr_i == ADDR_CHG_FLAGS_THREE)
      |=> (st_ff.flags.charger_event_flags_three & $past(st_ff.flags[15:8])) == $past(st_ff.flags[15:8]);
   endproperty
   a_three_holds: assert property (p_three_holds) else $error("held flag lost without a read");

   // Main scenarios
   c_timer_read: cover property (@(posedge mclk_i) disable iff (!arst_n_i)
      $rose(st_ff.flags.charger_event_flags_two[B2_TOP_OFF_TMR]) ##[1:20] rd_en_i);
   c_set_and_clear: cover property (@(posedge mclk_i) disable iff (!arst_n_i)
      rd_en_i && (rd_clr & evt) != 24'h000000);
   c_masked_event: cover property (@(posedge mclk_i) disable iff (!arst_n_i)
      evt != 24'h000000 && (evt & ~mask_vec) == 24'h000000);
   c_fault_pulse: cover property (@(posedge mclk_i) disable iff (!arst_n_i)
      int_pulse_o && st_ff.flags.fault_event_flags_zero != 8'h00);
   c_reset_levels_high: cover property (@(posedge mclk_i) disable iff (!arst_n_i)
      !st_ff.primed && lvl != 24'h000000);

endmodule : cef_flag_bank

`default_nettype wire

/* File: tb/cef_host_model.sv */
// Host side model that issues register reads to the flag bank
`timescale 1ns/100ps
`default_nettype none

module cef_host_model
   import cef_pkg::*;
(
   input wire logic mclk_i,
   input wire logic arst_n_i,
   input wire logic go_i,
   input wire logic [7:0] addr_i,
   output logic rd_en_o,
   output logic [7:0] rd_addr_o,
   input wire logic rd_valid_i,
   input wire logic [7:0] rd_data_i,
   output logic [7:0] data_o,
   output logic done_o
);
   // One strobe per request; idle address toggles so a stale value is never read as valid
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rd_en_o <= 1'h0;
         rd_addr_o <= 8'h00;
         data_o <= 8'h00;
         done_o <= 1'h0;
      end else begin
         rd_en_o <= go_i;
         rd_addr_o <= go_i ? addr_i : ~rd_addr_o;
         done_o <= rd_valid_i;
         if (rd_valid_i) begin
            data_o <= rd_data_i;
         end
      end
   end
endmodule : cef_host_model

`default_nettype wire

/* File: tb/charger_event_flag_bank_tb.sv */
// Self-checking bench for the charger event flag bank
`timescale 1ns/100ps
`default_nettype none

module charger_event_flag_bank_tb import cef_pkg::*;;
   // Flags that fire on any change of their level
   localparam logic [23:0] BOTH_EDGES = 24'h800F10;
   localparam logic [7:0] ADR [3] = '{8'h24, 8'h25, 8'h26};
   logic mclk_i, arst_n_i, go, done, rd_en, rd_valid, int_pulse;
   logic [7:0] addr, rd_addr, rd_data, data;
   logic [19:0] cond;
   logic [23:0] mask;
   int bad_count, cmp_count, cyc;

   cef_flag_bank dut_u (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .cond_i(cef_cond_s'(cond)),
      .mask_i(cef_bank_s'(mask)), .rd_en_i(rd_en), .rd_addr_i(rd_addr), .rd_data_o(rd_data),
      .rd_valid_o(rd_valid), .int_pulse_o(int_pulse));
   cef_host_model host_u (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .go_i(go), .addr_i(addr),
      .rd_en_o(rd_en), .rd_addr_o(rd_addr), .rd_valid_i(rd_valid), .rd_data_i(rd_data),
      .data_o(data), .done_o(done));

   ////////////////////////////////////////////////////////////////////////////////
   // Clock and hang guard
   initial begin
      mclk_i = 1'h0;
      forever #4 mclk_i = ~mclk_i;
   end
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 5000) begin
         bad_count++;
         $display("MISMATCH t=%0t timeout", $time);
         end_of_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Helpers
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   // Request one read through the host and compare the returned byte
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      int n;
      n = 0;
      @(posedge mclk_i);
      go <= 1'h1;
      addr <= a;
      @(posedge mclk_i);
      go <= 1'h0;
      do begin
         @(posedge mclk_i);
         #1;
         n++;
      end while (done !== 1'h1 && n < 8);
      chk({7'h00, done}, 8'h01, "read done");
      chk(data, exp, "read data");
   endtask : rd

   // Count interrupt pulse cycles after a level change
   task automatic pulse(input logic exp);
      int k;
      k = 0;
      repeat (3) begin
         @(posedge mclk_i);
         #1;
         if (int_pulse === 1'h1) k++;
      end
      chk(8'(k), {7'h00, exp}, "pulse count");
   endtask : pulse

   // Bank bit position of each condition bit
   function automatic int bpos(input int j);
      if (j < 8) return 16 + j;
      if (j < 13) return j;
      return j - 13;
   endfunction : bpos

   task automatic end_of_test();
      $display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_of_test

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      int p;
      logic m;
      logic [7:0] e;
      arst_n_i = 1'h0;
      go = 1'h0;
      addr = 8'h00;
      cond = 20'h00000;
      mask = 24'h000000;
      bad_count = 0;
      cmp_count = 0;
      cyc = 0;
      repeat (6) @(posedge mclk_i);
      arst_n_i <= 1'h1;
      for (int i = 0; i < 3; i++) rd(ADR[i], 8'h00);
      // Each event alone, every other one masked
      for (int j = 0; j < 20; j++) begin
         p = bpos(j);
         e = 8'h01 << (p % 8);
         m = j[0];
         @(posedge mclk_i);
         cond[j] <= 1'h1;
         mask[p] <= m;
         pulse(~m);
         rd(ADR[p / 8], e);
         rd(ADR[p / 8], 8'h00);
         @(posedge mclk_i);
         cond[j] <= 1'h0;
         pulse(BOTH_EDGES[p] & ~m);
         rd(ADR[p / 8], BOTH_EDGES[p] ? e : 8'h00);
      end
      // Unmapped read neither answers data nor clears
      @(posedge mclk_i);
      mask <= 24'h000000;
      cond[4] <= 1'h1;
      pulse(1'h1);
      rd(8'h27, 8'h00);
      rd(8'h26, 8'h10);
      // All levels high at once, reserved bits stay clear
      @(posedge mclk_i);
      cond <= 20'hFFFFF;
      pulse(1'h1);
      rd(8'h24, 8'h7F);
      rd(8'h25, 8'h1F);
      rd(8'h26, 8'hEF);
      // A read and a new event in one cycle: the read sees the old value, the flag survives
      @(posedge mclk_i);
      cond[13] <= 1'h0;
      fork
         rd(8'h24, 8'h00);
         begin
            repeat (2) @(posedge mclk_i);
            cond[13] <= 1'h1;
         end
      join
      rd(8'h24, 8'h01);
      // Reset in mid-run with every level high: flags clear and no event follows
      @(posedge mclk_i);
      arst_n_i <= 1'h0;
      repeat (2) @(posedge mclk_i);
      arst_n_i <= 1'h1;
      pulse(1'h0);
      for (int i = 0; i < 3; i++) rd(ADR[i], 8'h00);
      end_of_test();
   end
endmodule : charger_event_flag_bank_tb

`default_nettype wire
